/* File: hdl/encoder_fault_monitor.sv */
// Register access over APB and the address map were decided locally.
module encoder_fault_monitor #(
  parameter int              PHASE_CYC     = encoder_fault_pkg::PHASE_CYC_DEF,
  parameter int              REC_SHORT_CYC = encoder_fault_pkg::REC_SHORT_DEF,
  parameter int              REC_LONG_CYC  = encoder_fault_pkg::REC_LONG_DEF,
  // Arbitrary value
  parameter logic [3:0]      EXPECTED_ID   = 4'hA
) (
  input  wire logic                             ref_clk,
  input  wire logic                             nrst,
  input  wire logic [7:0]                       paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      pwdata,
  output logic [31:0]                           prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire encoder_fault_pkg::enc_in_t [1:0] enc_in,
  input  wire logic [1:0]                       suppress_main,
  input  wire logic [1:0]                       suppress_fb,
  output logic                                  first_encoder_supply_out,
  output logic                                  second_encoder_supply_out,
  output logic [1:0]                            status_valid,
  output logic [1:0]                            reliable,
  output logic [1:0]                            diag_event,
  output logic [1:0]                            module_err_flags,
  output logic                                  module_state_led,
  output logic                                  irq
);
  import encoder_fault_pkg::*;

  localparam int PW = $clog2(PHASE_CYC + 1);

  logic [1:0]      rst_sync_q;
  logic            rst_n;
  ctrl_t           ctrl_q;
  logic [3:0]      mask_q;
  logic [3:0]      stat_q;
  logic [3:0]      stat_ev;
  logic [PW-1:0]   ph_cnt_q;
  logic [PW-1:0]   ph_cnt_d;
  phase_t          phase_q;
  phase_t          phase_d;
  logic            sup_on;
  logic            tick;
  logic            first_q;
  logic            second_q;
  logic [1:0]      id_bad_q;
  logic [ID_W-1:0] id_last_q [2];
  logic [1:0]      sup_fb_q;
  logic [1:0]      sup_eff;
  logic [1:0]      bad;
  logic [1:0]      bad_prev_q;
  logic [1:0]      err_rise;
  logic [1:0]      recovered;
  logic [1:0]      diag_q;
  logic [1:0]      err_flag_q;
  logic            led_q;
  logic            wr_en;
  logic            setup;
  logic            hit;
  logic [31:0]     rd_mux;
  logic [31:0]     prdata_q;

  // ==========================================================
  // Reset release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Supply alternation
  assign sup_on = |ctrl_q.box;
  assign tick   = sup_on && (ph_cnt_q == PW'(PHASE_CYC));

  always_comb begin
    ph_cnt_d = ph_cnt_q + PW'(1);
    phase_d  = phase_q;
    if (!sup_on) begin
      ph_cnt_d = '0;
      phase_d  = PH_FIRST_ON;
    end else if (tick) begin
      ph_cnt_d = PW'(1);
      phase_d  = (phase_q == PH_FIRST_ON) ? PH_SECOND_ON : PH_FIRST_ON;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_cnt_q <= '0;
      phase_q  <= PH_FIRST_ON;
      first_q  <= 1'b1;
      second_q <= 1'b1;
    end else begin
      ph_cnt_q <= ph_cnt_d;
      phase_q  <= phase_d;
      first_q  <= !sup_on || (phase_d == PH_FIRST_ON);
      second_q <= !sup_on || (phase_d == PH_SECOND_ON);
    end
  end

  assign first_encoder_supply_out  = first_q;
  assign second_encoder_supply_out = second_q;

  // ==========================================================
  // Identity code sampling
  for (genvar c = 0; c < 2; c++) begin : g_id
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        id_bad_q[c]  <= 1'b0;
        id_last_q[c] <= '0;
      end else if (!ctrl_q.box[c]) begin
        id_bad_q[c] <= 1'b0;
      end else if (tick) begin
        id_last_q[c] <= (phase_q == PH_FIRST_ON) ? enc_in[c].id_second
                                                 : enc_in[c].id_first;
        id_bad_q[c]  <= ((phase_q == PH_FIRST_ON) ? enc_in[c].id_second
                                                  : enc_in[c].id_first) != EXPECTED_ID;
      end
    end
  end

  // ==========================================================
  // Suppress source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sup_fb_q <= 2'b00;
    else sup_fb_q <= suppress_fb;
  end
  assign sup_eff = (ctrl_q.sup_src_fb & sup_fb_q) | (~ctrl_q.sup_src_fb & suppress_main);

  // ==========================================================
  // Channel checkers
  for (genvar c = 0; c < 2; c++) begin : g_ch
    encoder_channel_check #(
      .REC_SHORT_CYC (REC_SHORT_CYC),
      .REC_LONG_CYC  (REC_LONG_CYC)
    ) u_chk (
      .clk         (ref_clk),
      .rst_n       (rst_n),
      .enc         (enc_in[c]),
      .sincos_on   (ctrl_q.sc_mon[c] && ctrl_q.type_sincos[c]),
      .id_bad      (id_bad_q[c]),
      .suppress    (sup_eff[c]),
      .valid_q     (status_valid[c]),
      .reliable_q  (reliable[c]),
      .bad         (bad[c]),
      .recovered_q (recovered[c])
    );
  end

  // ==========================================================
  // Error reporting
  assign err_rise = bad & ~bad_prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_prev_q <= 2'b00;
      diag_q     <= 2'b00;
      err_flag_q <= 2'b00;
      led_q      <= 1'b0;
    end else begin
      bad_prev_q <= bad;
      diag_q     <= err_rise & ~sup_eff;
      err_flag_q <= bad & ~sup_eff;
      led_q      <= |(bad & ~sup_eff);
    end
  end

  assign diag_event       = diag_q;
  assign module_err_flags = err_flag_q;
  assign module_state_led = led_q;

  // ==========================================================
  // Interrupts
  assign stat_ev = {recovered, err_rise & ~sup_eff};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) stat_q <= 4'h0;
    else if (wr_en && paddr == ADDR_IRQ_STAT) stat_q <= (stat_q & ~pwdata[3:0]) | stat_ev;
    else stat_q <= stat_q | stat_ev;
  end

  assign irq = |(stat_q & mask_q);

  // ==========================================================
  // APB slave
  assign wr_en   = psel && penable && pwrite;
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      rd_mux[9:0] = ctrl_q;
    end else if (paddr == ADDR_STATUS) begin
      rd_mux[6:0] = {phase_q, bad, reliable, status_valid};
    end else if (paddr == ADDR_IRQ_STAT) begin
      rd_mux[3:0] = stat_q;
    end else if (paddr == ADDR_IRQ_MASK) begin
      rd_mux[3:0] = mask_q;
    end else if (paddr == ADDR_ID_MEAS) begin
      rd_mux[2*ID_W-1:0] = {id_last_q[1], id_last_q[0]};
    end else begin
      hit = 1'b0;
    end
  end

  assign pslverr = psel && penable && !hit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) prdata_q <= 32'h0000_0000;
    else if (setup) prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata[9:0];
      else if (paddr == ADDR_IRQ_MASK) mask_q <= pwdata[3:0];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_supply_alt;
    sup_on && $past(sup_on) && $past(sup_on, 2) |-> first_q != second_q;
  endproperty
  a_supply_alt: assert property (p_supply_alt) else $error("supplies not alternating");

  property p_supply_hold;
    sup_on && $past(sup_on, 2) && $changed(first_q) |-> $past(tick);
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("supply switched early");

  property p_no_box;
    !sup_on |=> first_q && second_q;
  endproperty
  a_no_box: assert property (p_no_box) else $error("supplies switched without box");

  property p_id_invalid;
    id_bad_q[0] |=> !status_valid[0];
  endproperty
  a_id_invalid: assert property (p_id_invalid) else $error("status stays valid");

  property p_id_sample;
    tick && ctrl_q.box[1] && phase_q == PH_FIRST_ON |=>
      id_last_q[1] == $past(enc_in[1].id_second);
  endproperty
  a_id_sample: assert property (p_id_sample) else $error("wrong supply sampled");

  property p_recover_clean;
    $rose(status_valid[1]) |-> !$past(bad[1]) && !$past(bad[1], 2);
  endproperty
  a_recover_clean: assert property (p_recover_clean) else $error("early recovery");

  property p_sc_unreliable;
    bad[0] && !id_bad_q[0] |=> !reliable[0];
  endproperty
  a_sc_unreliable: assert property (p_sc_unreliable) else $error("reliable stays set");

  property p_diag_muted;
    diag_q[0] |-> !$past(sup_eff[0]);
  endproperty
  a_diag_muted: assert property (p_diag_muted) else $error("diag not muted");

  property p_led_muted;
    sup_eff[1] && !bad[0] |=> !led_q;
  endproperty
  a_led_muted: assert property (p_led_muted) else $error("led not muted");

  property p_react_under_suppress;
    id_bad_q[1] && sup_eff[1] |=> !status_valid[1];
  endproperty
  a_react_under_suppress: assert property (p_react_under_suppress)
    else $error("suppress blocked reaction");

  property p_fb_delay;
    ctrl_q.sup_src_fb[0] |-> sup_eff[0] == $past(suppress_fb[0]);
  endproperty
  a_fb_delay: assert property (p_fb_delay) else $error("fb suppress not delayed");

  c_recover: cover property ($rose(status_valid[0]));
  c_id_fault: cover property ($rose(id_bad_q[0]));
  c_sc_fault: cover property ($fell(reliable[0]));
  c_irq: cover property ($rose(irq));

endmodule : encoder_fault_monitor

/* File: common/encoder_fault_pkg.sv */
package encoder_fault_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int PHASE_MS       = 4;
  localparam int REC_SHORT_MS   = 140;
  localparam int REC_LONG_MS    = 1000;
  localparam int REC_TOL_MS     = 20;
  localparam int PHASE_CYC_DEF  = CYC_PER_MS * PHASE_MS;
  localparam int REC_SHORT_DEF  = CYC_PER_MS * REC_SHORT_MS;
  localparam int REC_LONG_DEF   = CYC_PER_MS * REC_LONG_MS;

  // ==========================================================
  // Encoder signals and sin/cos limits
  localparam int               ID_W      = 4;
  localparam int               AW        = 16;
  localparam logic [AW-1:0]    VEC_LO    = 16'h2000;
  localparam logic [AW-1:0]    VEC_HI    = 16'h6000;
  localparam logic [AW:0]      MIN_MOVE  = 17'h0_1000;
  localparam logic [AW:0]      MIN_DEV   = 17'h0_0400;
  localparam logic [2*AW:0]    VEC_LO_SQ = 33'(VEC_LO) * 33'(VEC_LO);
  localparam logic [2*AW:0]    VEC_HI_SQ = 33'(VEC_HI) * 33'(VEC_HI);

  // ==========================================================
  // Register map
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_ID_MEAS  = 8'h10;
  localparam logic [9:0]  CTRL_RST      = 10'h000;
  localparam logic [3:0]  MASK_RST      = 4'h0;

  typedef struct packed {
    logic [1:0] sup_src_fb;
    logic [1:0] ext_supply;
    logic [1:0] type_sincos;
    logic [1:0] sc_mon;
    logic [1:0] box;
  } ctrl_t;

  typedef struct packed {
    logic signed [AW-1:0] sin;
    logic signed [AW-1:0] cos;
    logic                 sample;
    logic [ID_W-1:0]      id_first;
    logic [ID_W-1:0]      id_second;
  } enc_in_t;

  typedef enum logic [0:0] {
    PH_FIRST_ON  = 1'b0,
    PH_SECOND_ON = 1'b1
  } phase_t;

endpackage : encoder_fault_pkg

/* File: hdl/encoder_channel_check.sv */
module encoder_channel_check #(
  parameter int REC_SHORT_CYC = encoder_fault_pkg::REC_SHORT_DEF,
  parameter int REC_LONG_CYC  = encoder_fault_pkg::REC_LONG_DEF
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire encoder_fault_pkg::enc_in_t             enc,
  input  wire logic                                   sincos_on,
  input  wire logic                                   id_bad,
  input  wire logic                                   suppress,
  output logic                                        valid_q,
  output logic                                        reliable_q,
  output logic                                        bad,
  output logic                                        recovered_q
);
  import encoder_fault_pkg::*;

  localparam int RW = $clog2(REC_LONG_CYC + 1);

  logic                 sc_fault_q;
  logic signed [AW-1:0] sin_ref_q;
  logic signed [AW-1:0] cos_ref_q;
  logic [2*AW:0]        mag_sq;
  logic [AW:0]          ds;
  logic [AW:0]          dc;
  logic                 vec_bad;
  logic                 dev_bad;
  logic                 moved;
  logic [RW-1:0]        cnt_q;
  logic                 rec_q;
  logic                 done;

  function automatic logic [AW:0] absdiff(input logic signed [AW-1:0] a,
                                          input logic signed [AW-1:0] b);
    logic signed [AW:0] d;
    d = (AW+1)'(a) - (AW+1)'(b);
    return d[AW] ? (AW+1)'(-d) : (AW+1)'(d);
  endfunction : absdiff

  // ==========================================================
  // Sin/cos plausibility
  always_comb begin
    mag_sq  = (2*AW+1)'(enc.sin * enc.sin) + (2*AW+1)'(enc.cos * enc.cos);
    vec_bad = (mag_sq < VEC_LO_SQ) || (mag_sq > VEC_HI_SQ);
    ds      = absdiff(enc.sin, sin_ref_q);
    dc      = absdiff(enc.cos, cos_ref_q);
    moved   = (dc >= MIN_MOVE) || (ds >= MIN_MOVE);
    dev_bad = ((dc >= MIN_MOVE) && (ds < MIN_DEV)) || ((ds >= MIN_MOVE) && (dc < MIN_DEV));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_fault_q <= 1'b0;
      sin_ref_q  <= '0;
      cos_ref_q  <= '0;
    end else if (!sincos_on) begin
      sc_fault_q <= 1'b0;
      sin_ref_q  <= enc.sin;
      cos_ref_q  <= enc.cos;
    end else if (enc.sample) begin
      sc_fault_q <= vec_bad || dev_bad;
      if (moved) begin
        sin_ref_q <= enc.sin;
        cos_ref_q <= enc.cos;
      end
    end
  end

  assign bad  = id_bad || sc_fault_q;
  assign done = rec_q && !bad &&
                (((cnt_q == RW'(REC_SHORT_CYC - 1)) && suppress) ||
                 (cnt_q == RW'(REC_LONG_CYC - 1)));

  // ==========================================================
  // Error recovery
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= '0;
      rec_q      <= 1'b1;
      valid_q    <= 1'b0;
      reliable_q <= 1'b0;
    end else if (bad) begin
      cnt_q <= '0;
      rec_q <= 1'b1;
      if (id_bad) valid_q <= 1'b0;
      if (sc_fault_q) reliable_q <= 1'b0;
    end else if (done) begin
      cnt_q      <= '0;
      rec_q      <= 1'b0;
      valid_q    <= 1'b1;
      reliable_q <= 1'b1;
    end else if (rec_q) begin
      cnt_q <= cnt_q + RW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) recovered_q <= 1'b0;
    else recovered_q <= done;
  end

endmodule : encoder_channel_check

/* File: dv/encoder_box_model.sv */
module encoder_box_model (
  input  wire logic                                     ref_clk,
  input  wire logic                                     first_on,
  input  wire logic                                     second_on,
  input  wire logic [1:0][encoder_fault_pkg::ID_W-1:0]  box_id,
  input  wire logic [1:0][encoder_fault_pkg::AW-1:0]    sin_v,
  input  wire logic [1:0][encoder_fault_pkg::AW-1:0]    cos_v,
  output encoder_fault_pkg::enc_in_t [1:0]              enc
);
  timeunit 1ns;
  timeprecision 1ns;
  import encoder_fault_pkg::*;

  logic [1:0] div_q = 2'h0;

  // ==========================================================
  // New sin/cos sample every fourth cycle
  always_ff @(posedge ref_clk) begin
    div_q <= div_q + 2'h1;
  end

  // ==========================================================
  // Code reads true only through the supply that is off
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      enc[c].sin       = sin_v[c];
      enc[c].cos       = cos_v[c];
      enc[c].sample    = (div_q == 2'h0);
      enc[c].id_first  = first_on ? ~box_id[c] : box_id[c];
      enc[c].id_second = second_on ? ~box_id[c] : box_id[c];
    end
  end
endmodule : encoder_box_model

/* File: dv/encoder_fault_monitor_bench.sv */
module encoder_fault_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import encoder_fault_pkg::*;

  localparam int         PH    = 8;
  localparam int         RS    = 20;
  localparam int         RL    = 60;
  // Arbitrary value
  localparam logic [3:0] ID_OK = 4'hA;

  logic                  ref_clk       = 1'h0;
  logic                  nrst          = 1'h0;
  logic [7:0]            paddr         = 8'h00;
  logic                  psel          = 1'h0;
  logic                  penable       = 1'h0;
  logic                  pwrite        = 1'h0;
  logic [31:0]           pwdata        = 32'h0000_0000;
  logic [1:0]            suppress_main = 2'h0;
  logic [1:0]            suppress_fb   = 2'h0;
  logic [1:0][ID_W-1:0]  box_id        = {2{ID_OK}};
  logic [1:0][AW-1:0]    sin_v         = {2{16'h4000}};
  logic [1:0][AW-1:0]    cos_v         = '0;
  logic [2:0][AW-1:0]    ts            = {16'h4000, 16'h1000, 16'h7000};
  logic [2:0][AW-1:0]    tc            = {16'h1800, 16'h1000, 16'h1000};
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  enc_in_t [1:0]         enc_in;
  logic                  first_encoder_supply_out;
  logic                  second_encoder_supply_out;
  logic [1:0]            status_valid;
  logic [1:0]            reliable;
  logic [1:0]            diag_event;
  logic [1:0]            module_err_flags;
  logic                  module_state_led;
  logic                  irq;
  logic [31:0]           rd;
  logic                  er;
  logic                  lv;
  int                    n;
  int                    d0;
  int                    diag_cnt      = 0;
  int                    cyc           = 0;
  int                    error_cnt     = 0;
  int                    compares      = 0;

  encoder_fault_monitor #(
    .PHASE_CYC(PH), .REC_SHORT_CYC(RS), .REC_LONG_CYC(RL), .EXPECTED_ID(ID_OK)
  ) u_encoder_fault_monitor (
    .ref_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .enc_in, .suppress_main, .suppress_fb, .first_encoder_supply_out,
    .second_encoder_supply_out, .status_valid, .reliable, .diag_event,
    .module_err_flags, .module_state_led, .irq
  );

  encoder_box_model u_encoder_box_model (
    .ref_clk, .first_on(first_encoder_supply_out), .second_on(second_encoder_supply_out),
    .box_id, .sin_v, .cos_v, .enc(enc_in)
  );

  // ==========================================================
  // Clock, timeout and diagnostic pulse count
  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    diag_cnt <= diag_cnt + int'(diag_event[0]) + int'(diag_event[1]);
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  // ==========================================================
  // Shared tasks
  task summarize;
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  function automatic logic pick(input int sel, input int ch);
    return (sel == 0) ? status_valid[ch] : reliable[ch];
  endfunction : pick

  task wait_for(input int sel, input int ch, input logic v, input int lim);
    n = 0;
    while (pick(sel, ch) !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_for

  // ==========================================================
  // Scenarios
  task t_reset;
    repeat (6) @(posedge ref_clk);
    check("supplies", {first_encoder_supply_out, second_encoder_supply_out}, 2'h3);
    check("valid_rst", status_valid, 2'h0);
    check("rel_rst", reliable, 2'h0);
    nrst <= 1'h1;
    wait_for(0, 0, 1'h1, RL + 20);
    check("rec_long", 32'(n >= RL && n <= RL + 6), 32'h1);
    repeat (2) @(posedge ref_clk);
    check("both_ok", {status_valid, reliable}, 4'hF);
    apb(1'h1, ADDR_STATUS, 32'h0000_0000);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    check("status", rd & 32'h0000_003F, 32'h0000_000F);
    apb(1'h0, ADDR_CTRL, 32'h0000_0000);
    check("ctrl_rst", rd, 32'h0000_0000);
    apb(1'h0, ADDR_IRQ_MASK, 32'h0000_0000);
    check("mask_rst", rd, 32'h0000_0000);
    apb(1'h1, 8'h14, 32'hFFFF_FFFF);
    check("unmapped_wr", er, 1'h1);
    apb(1'h0, 8'h14, 32'h0000_0000);
    check("unmapped_rd", rd, 32'h0000_0000);
    check("unmapped_err", er, 1'h1);
  endtask : t_reset

  task t_supply;
    apb(1'h1, ADDR_CTRL, 32'h0000_0003);
    n = 0;
    while (!(first_encoder_supply_out && !second_encoder_supply_out) && n < PH + 6) begin
      @(posedge ref_clk);
      n++;
    end
    check("first_phase", 32'(n <= PH + 4), 32'h1);
    for (int k = 0; k < 4; k++) begin
      n = 0;
      lv = first_encoder_supply_out;
      while (first_encoder_supply_out === lv && n < 2 * PH) begin
        @(posedge ref_clk);
        n++;
      end
      check("phase_len", n, PH);
      check("one_on", first_encoder_supply_out ^ second_encoder_supply_out, 1'h1);
    end
    check("valid_kept", status_valid, 2'h3);
    apb(1'h0, ADDR_ID_MEAS, 32'h0000_0000);
    check("id_meas", rd, 32'({ID_OK, ID_OK}));
  endtask : t_supply

  task t_idfault(input int ch, input logic sup, input logic fb);
    @(posedge ref_clk);
    if (fb) begin
      apb(1'h1, ADDR_CTRL, 32'h0000_0003 | (32'h0000_0100 << ch));
      suppress_fb[ch] <= sup;
    end else begin
      suppress_main[ch] <= sup;
    end
    box_id[ch] <= 4'h5;
    d0 = diag_cnt;
    wait_for(0, ch, 1'h0, 2 * PH + 6);
    check("id_drop", status_valid[ch], 1'h0);
    repeat (3) @(posedge ref_clk);
    check("err_flag", module_err_flags[ch], !sup);
    check("led", module_state_led, !sup);
    check("diag", 32'(diag_cnt != d0), 32'(!sup));
    box_id[ch] <= ID_OK;
    wait_for(0, ch, 1'h1, RL + 3 * PH);
    d0 = sup ? RS : RL;
    check("rec_time", 32'(n >= d0 && n <= d0 + 2 * PH + 6), 32'h1);
    apb(1'h0, ADDR_IRQ_STAT, 32'h0000_0000);
    check("onset", rd[ch], !sup);
    check("recovered", rd[2 + ch], 1'h1);
    apb(1'h1, ADDR_IRQ_MASK, 32'h0000_0001 << ch);
    @(posedge ref_clk);
    check("irq_on", irq, !sup);
    apb(1'h1, ADDR_IRQ_STAT, 32'h0000_0005 << ch);
    @(posedge ref_clk);
    check("irq_clr", irq, 1'h0);
    apb(1'h1, ADDR_IRQ_MASK, 32'h0000_0000);
    suppress_main[ch] <= 1'h0;
    suppress_fb[ch] <= 1'h0;
    if (fb) apb(1'h1, ADDR_CTRL, 32'h0000_0003);
  endtask : t_idfault

  task t_sincos;
    apb(1'h1, ADDR_CTRL, 32'h0000_00CF);
    sin_v[0] <= ts[0];
    cos_v[0] <= tc[0];
    repeat (12) @(posedge ref_clk);
    check("ab_rel", reliable[0], 1'h1);
    sin_v[0] <= 16'h4000;
    cos_v[0] <= 16'h0000;
    apb(1'h1, ADDR_CTRL, 32'h0000_00DF);
    wait_for(1, 0, 1'h1, RL + 12);
    for (int k = 0; k < 3; k++) begin
      sin_v[0] <= ts[k];
      cos_v[0] <= tc[k];
      wait_for(1, 0, 1'h0, 12);
      check("vec_fault", reliable[0], 1'h0);
      sin_v[0] <= 16'h4000;
      cos_v[0] <= 16'h0000;
      wait_for(1, 0, 1'h1, RL + 16);
      check("vec_rec", 32'(n >= RL && n <= RL + 14), 32'h1);
    end
  endtask : t_sincos

  initial begin
    t_reset();
    t_supply();
    t_idfault(0, 1'h0, 1'h0);
    t_idfault(1, 1'h1, 1'h0);
    t_idfault(0, 1'h1, 1'h1);
    t_sincos();
    summarize();
  end
endmodule : encoder_fault_monitor_bench
